// ==== bnk_defines.svh ====
// Purpose: shared constants of the banked file-register block
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef BNK_DEFINES_SVH
`define BNK_DEFINES_SVH

`define BNK_OPC_W        12
`define BNK_SEL_W        5
`define BNK_SEL_MSB      4
`define BNK_SEL_LSB      0
`define BNK_BNUM_MSB     2
`define BNK_BNUM_LSB     0
`define BNK_DATA_W       8
`define BNK_BANK_W       3
`define BNK_NUM_BANKS    8
`define BNK_BANK_MSB     7
`define BNK_BANK_LSB     5
`define BNK_HALF_BIT     4
`define BNK_GP_BIT       3
`define BNK_GP_LO_MSB    2
`define BNK_IDX_W        8
`define BNK_GP_GLOBALS   8'h08
`define BNK_GP_TOTAL     136
`define BNK_SEL_INDIRECT 5'h00
`define BNK_OFF_INDIRECT 5'h00
`define BNK_OFF_RTC      5'h01
`define BNK_OFF_PCL      5'h02
`define BNK_OFF_STATUS   5'h03
`define BNK_OFF_POINTER  5'h04
`define BNK_OFF_PORT_A   5'h05
`define BNK_OFF_PORT_B   5'h06
`define BNK_OFF_PORT_C   5'h07
`define BNK_RESET_BYTE   8'h00
`define BNK_ZERO_BYTE    8'h00
`define BNK_BANK0        3'h0

`endif

// ==== bnk_pkg.sv ====
// Purpose: types of the banked file-register block
// Assumes: nothing beyond the defines header
// Notes:   mode codes are also driven out of the top module
`include "bnk_defines.svh"
`default_nettype none
package bnk_pkg;
  typedef enum logic [1:0] {
    BNK_MODE_INDIRECT = 2'b00,
    BNK_MODE_GLOBAL   = 2'b01,
    BNK_MODE_BANKED   = 2'b10
  } bnk_mode_e;
  typedef logic [`BNK_DATA_W-1:0] bnk_byte_t;
  typedef logic [`BNK_SEL_W-1:0]  bnk_sel_t;
  typedef logic [`BNK_BANK_W-1:0] bnk_num_t;
  typedef logic [`BNK_IDX_W-1:0]  bnk_idx_t;
endpackage
`default_nettype wire

// ==== bnk_acc_if.sv ====
// Purpose: selector-to-address resolution carrier
// Assumes: one decoder and one user
// Notes:   purely combinational signals
`include "bnk_defines.svh"
`default_nettype none
interface bnk_acc_if;
  import bnk_pkg::*;
  bnk_sel_t  sel;
  bnk_byte_t pointer;
  bnk_mode_e mode;
  bnk_byte_t phys_addr;
  logic      is_global;
  logic      gp_hit;
  bnk_idx_t  gp_index;
  modport decoder (input sel, pointer,
                   output mode, phys_addr, is_global, gp_hit, gp_index);
  modport user    (output sel, pointer,
                   input mode, phys_addr, is_global, gp_hit, gp_index);
endinterface
`default_nettype wire

// ==== bnk_decode.sv ====
// Purpose: turns a register selector and the pointer into an address
// Assumes: pointer comes from a register on the same clock
// Notes:   combinational only
`include "bnk_defines.svh"
`default_nettype none
module bnk_decode
  import bnk_pkg::*;
(
  bnk_acc_if.decoder acc
);
  // global general registers take slots 0..7, bank upper halves follow
  function automatic bnk_idx_t gp_slot(input bnk_byte_t a);
    if (a[`BNK_HALF_BIT])
      gp_slot = `BNK_GP_GLOBALS
              + {a[`BNK_BANK_MSB:`BNK_BANK_LSB], a[`BNK_HALF_BIT-1:0]};
    else
      gp_slot = bnk_idx_t'(a[`BNK_GP_LO_MSB:0]);
  endfunction

  always_comb begin
    acc.mode      = BNK_MODE_GLOBAL;
    acc.phys_addr = {{`BNK_BANK_W{1'b0}}, acc.sel};
    if (acc.sel == `BNK_SEL_INDIRECT) begin
      acc.mode      = BNK_MODE_INDIRECT;
      acc.phys_addr = acc.pointer;
    end else if (acc.sel[`BNK_HALF_BIT]) begin
      acc.mode      = BNK_MODE_BANKED;
      acc.phys_addr = {acc.pointer[`BNK_BANK_MSB:`BNK_BANK_LSB], acc.sel};
    end
  end

  // a clear bit 4 always lands in the global set, also through the pointer
  assign acc.is_global = !acc.phys_addr[`BNK_HALF_BIT];
  assign acc.gp_hit    = !acc.is_global || acc.phys_addr[`BNK_GP_BIT];
  assign acc.gp_index  = gp_slot(acc.phys_addr);
endmodule
`default_nettype wire

// ==== bnk_store.sv ====
// Purpose: general-purpose byte storage of the register file
// Assumes: index already resolved by the decoder
// Notes:   contents are not reset, as with plain RAM
`include "bnk_defines.svh"
`default_nettype none
module bnk_store #(
  parameter int W     = `BNK_DATA_W,
  parameter int DEPTH = `BNK_GP_TOTAL,
  parameter int IDX_W = `BNK_IDX_W
) (
  input  wire logic             clk,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_index,
  input  wire logic [W-1:0]     wr_data,
  input  wire logic [IDX_W-1:0] rd_index,
  output logic      [W-1:0]     rd_data
);
  if (DEPTH < 1 || $clog2(DEPTH) > IDX_W) begin : g_chk
    $error("bnk_store: depth does not fit the index width");
  end

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (clk_en && wr_en && int'(wr_index) < DEPTH) begin
      mem[wr_index] <= wr_data;
    end
  end

  // out-of-range reads give zero rather than an undefined word
  assign rd_data = (int'(rd_index) < DEPTH) ? mem[rd_index] : '0;
endmodule
`default_nettype wire

// ==== bnk_regfile.sv ====
// Purpose: banked data-memory register file of a small 8-bit core
// Assumes: the core presents one access per cycle on its own clock
// Notes:   read data returns one cycle after the access is taken
`include "bnk_defines.svh"
`default_nettype none
module bnk_regfile
  import bnk_pkg::*;
#(
  parameter int DATA_W = `BNK_DATA_W,
  parameter int BANKS  = `BNK_NUM_BANKS
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic [`BNK_OPC_W-1:0] instr_opcode,
  input  wire logic                  acc_valid,
  input  wire logic                  acc_write,
  input  wire logic [DATA_W-1:0]     wr_data,
  input  wire logic                  bank_strobe,
  output logic      [DATA_W-1:0]     rd_data,
  output logic                       rd_valid,
  output logic      [DATA_W-1:0]     bank_pointer,
  output logic      [`BNK_BANK_W-1:0] current_bank,
  output logic      [DATA_W-1:0]     access_addr,
  output logic      [1:0]            access_mode,
  output logic      [DATA_W-1:0]     realtime_counter_value,
  output logic      [DATA_W-1:0]     program_counter_low,
  output logic      [DATA_W-1:0]     status_flags,
  output logic      [DATA_W-1:0]     port_a_data,
  output logic      [DATA_W-1:0]     port_b_data,
  output logic      [DATA_W-1:0]     port_c_data
);
  if (DATA_W != `BNK_DATA_W || BANKS != `BNK_NUM_BANKS) begin : g_chk
    $error("bnk_regfile: only 8-bit registers in 8 banks are served");
  end

  bnk_acc_if acc ();

  bnk_sel_t  sel;
  bnk_num_t  bank_arg;
  bnk_sel_t  gidx;
  logic      rd_go;
  logic      wr_go;
  logic      glob_wr;
  logic      ptr_wr;
  logic      bank_go;
  logic      gp_wr;
  bnk_byte_t store_rd;
  bnk_byte_t rd_next;
  bnk_byte_t ptr_next;
  bnk_byte_t ptr_reg;
  bnk_byte_t rtc_reg;
  bnk_byte_t pcl_reg;
  bnk_byte_t status_reg;
  bnk_byte_t port_a_reg;
  bnk_byte_t port_b_reg;
  bnk_byte_t port_c_reg;
  bnk_byte_t rd_data_reg;
  logic      rd_valid_reg;
  bnk_byte_t addr_reg;
  bnk_mode_e mode_reg;

  // the same opcode field carries the bank number for the bank command
  assign sel      = instr_opcode[`BNK_SEL_MSB:`BNK_SEL_LSB];
  assign bank_arg = instr_opcode[`BNK_BNUM_MSB:`BNK_BNUM_LSB];

  assign acc.sel     = sel;
  assign acc.pointer = ptr_reg;

  bnk_decode u_decode (
    .acc (acc)
  );

  assign gidx    = {1'b0, acc.phys_addr[`BNK_HALF_BIT-1:0]};
  assign rd_go   = clk_en && acc_valid && !acc_write;
  assign wr_go   = clk_en && acc_valid && acc_write;
  assign glob_wr = wr_go && acc.is_global && !acc.gp_hit;
  assign ptr_wr  = glob_wr && gidx == `BNK_OFF_POINTER;
  // a plain pointer write in the same cycle overrides the bank command
  assign bank_go = clk_en && bank_strobe && !ptr_wr;
  assign gp_wr   = wr_go && acc.gp_hit;

  bnk_store #(
    .W     (`BNK_DATA_W),
    .DEPTH (`BNK_GP_TOTAL),
    .IDX_W (`BNK_IDX_W)
  ) u_store (
    .clk      (clk),
    .clk_en   (clk_en),
    .wr_en    (gp_wr),
    .wr_index (acc.gp_index),
    .wr_data  (wr_data),
    .rd_index (acc.gp_index),
    .rd_data  (store_rd)
  );

  always_comb begin
    ptr_next = ptr_reg;
    if (ptr_wr) begin
      ptr_next = wr_data;
    end else if (bank_go) begin
      ptr_next[`BNK_BANK_MSB:`BNK_BANK_LSB] = bank_arg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_reg <= `BNK_RESET_BYTE;
    end else if (clk_en) begin
      ptr_reg <= ptr_next;
    end
  end

  // dedicated globals in their fixed order; 00h holds no storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rtc_reg    <= `BNK_RESET_BYTE;
      pcl_reg    <= `BNK_RESET_BYTE;
      status_reg <= `BNK_RESET_BYTE;
      port_a_reg <= `BNK_RESET_BYTE;
      port_b_reg <= `BNK_RESET_BYTE;
      port_c_reg <= `BNK_RESET_BYTE;
    end else if (glob_wr) begin
      unique case (gidx)
        `BNK_OFF_RTC:    rtc_reg    <= wr_data;
        `BNK_OFF_PCL:    pcl_reg    <= wr_data;
        `BNK_OFF_STATUS: status_reg <= wr_data;
        `BNK_OFF_PORT_A: port_a_reg <= wr_data;
        `BNK_OFF_PORT_B: port_b_reg <= wr_data;
        `BNK_OFF_PORT_C: port_c_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // the indirect port reached through itself reads zero
  always_comb begin
    rd_next = store_rd;
    if (!acc.gp_hit) begin
      unique case (gidx)
        `BNK_OFF_INDIRECT: rd_next = `BNK_ZERO_BYTE;
        `BNK_OFF_RTC:      rd_next = rtc_reg;
        `BNK_OFF_PCL:      rd_next = pcl_reg;
        `BNK_OFF_STATUS:   rd_next = status_reg;
        `BNK_OFF_POINTER:  rd_next = ptr_reg;
        `BNK_OFF_PORT_A:   rd_next = port_a_reg;
        `BNK_OFF_PORT_B:   rd_next = port_b_reg;
        `BNK_OFF_PORT_C:   rd_next = port_c_reg;
        default:           rd_next = `BNK_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_reg <= `BNK_ZERO_BYTE;
    end else if (rd_go) begin
      rd_data_reg <= rd_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rd_valid_reg <= rd_go;
    end
  end

  // resolved address of the last access, for the core's debug view
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg <= `BNK_ZERO_BYTE;
      mode_reg <= BNK_MODE_GLOBAL;
    end else if (clk_en && acc_valid) begin
      addr_reg <= acc.phys_addr;
      mode_reg <= acc.mode;
    end
  end

  assign rd_data                = rd_data_reg;
  assign rd_valid               = rd_valid_reg;
  assign bank_pointer           = ptr_reg;
  assign current_bank           =
    ptr_reg[`BNK_BANK_MSB:`BNK_BANK_LSB];
  assign access_addr            = addr_reg;
  assign access_mode            = mode_reg;
  assign realtime_counter_value = rtc_reg;
  assign program_counter_low    = pcl_reg;
  assign status_flags           = status_reg;
  assign port_a_data            = port_a_reg;
  assign port_b_data            = port_b_reg;
  assign port_c_data            = port_c_reg;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_gp_glob_wr;
    wr_go && acc.mode == BNK_MODE_GLOBAL && sel[`BNK_GP_BIT];
  endsequence

  sequence s_same_sel_rd;
    rd_go && sel == $past(sel);
  endsequence

  sequence s_bank_cmd;
    bank_go && !wr_go;
  endsequence

  sequence s_banked_wr;
    wr_go && sel[`BNK_HALF_BIT];
  endsequence

  AST_RESET_BANK0: assert property (
    $rose(reset_n) |-> current_bank == `BNK_BANK0)
    else $error("bank not zero after reset");

  AST_SEL_FIELD: assert property (
    clk_en && acc_valid && acc.mode == BNK_MODE_GLOBAL
    |=> access_addr == {{`BNK_BANK_W{1'b0}},
                        $past(instr_opcode[`BNK_SEL_MSB:`BNK_SEL_LSB])})
    else $error("direct address not taken from opcode");

  AST_FULL_PTR_WRITE: assert property (
    ptr_wr |=> bank_pointer == $past(wr_data))
    else $error("pointer write did not replace all bits");

  AST_BANK_CMD: assert property (
    s_bank_cmd |=> current_bank == $past(bank_arg)
      && bank_pointer[`BNK_HALF_BIT:0] ==
         $past(bank_pointer[`BNK_HALF_BIT:0]))
    else $error("bank command touched the wrong pointer bits");

  AST_BANK_HOLDS: assert property (
    !bank_go && !ptr_wr |=> $stable(current_bank))
    else $error("current bank changed without a command");

  AST_INDIRECT_ADDR: assert property (
    clk_en && acc_valid && sel == `BNK_SEL_INDIRECT
    |=> access_addr == $past(bank_pointer)
      && access_mode == BNK_MODE_INDIRECT)
    else $error("indirect access ignored the pointer");

  AST_INDIRECT_SELF: assert property (
    rd_go && sel == `BNK_SEL_INDIRECT
      && bank_pointer == `BNK_ZERO_BYTE
    |=> rd_valid && rd_data == `BNK_ZERO_BYTE)
    else $error("indirect port through itself not zero");

  AST_DIRECT_IGNORES_PTR: assert property (
    clk_en && acc_valid && sel != `BNK_SEL_INDIRECT
      && !sel[`BNK_HALF_BIT]
    |=> access_addr[`BNK_DATA_W-1:`BNK_HALF_BIT] == '0
      && access_mode == BNK_MODE_GLOBAL)
    else $error("direct access left bank 0");

  AST_BANKED_ADDR: assert property (
    clk_en && acc_valid && sel[`BNK_HALF_BIT]
    |=> access_addr == {$past(current_bank), $past(sel)}
      && access_mode == BNK_MODE_BANKED)
    else $error("banked address not formed from pointer bits");

  AST_GLOBAL_SAME: assert property (
    s_gp_glob_wr ##1 s_same_sel_rd |=> rd_data == $past(wr_data, 2))
    else $error("global register differs between banks");

  AST_BANKED_BACK: assert property (
    s_banked_wr ##1 (s_same_sel_rd and !$changed(current_bank))
    |=> rd_data == $past(wr_data, 2))
    else $error("banked register lost its value");

  AST_PORT_WRITE: assert property (
    glob_wr && gidx == `BNK_OFF_PORT_A
    |=> port_a_data == $past(wr_data) && $stable(status_flags))
    else $error("port A write misrouted");

  AST_STATUS_WRITE: assert property (
    glob_wr && gidx == `BNK_OFF_STATUS
    |=> status_flags == $past(wr_data) && $stable(port_a_data))
    else $error("status write misrouted");

  AST_POINTER_AT_04: assert property (
    rd_go && acc.mode == BNK_MODE_GLOBAL && sel == `BNK_OFF_POINTER
    |=> rd_data == $past(bank_pointer))
    else $error("pointer not readable at its offset");

  AST_MIRROR: assert property (
    acc.mode == BNK_MODE_INDIRECT && !bank_pointer[`BNK_HALF_BIT]
    |-> acc.is_global
      && acc.phys_addr[`BNK_HALF_BIT-1:0] ==
         bank_pointer[`BNK_HALF_BIT-1:0])
    else $error("indirect lower half did not mirror globals");

  AST_GP_RANGE: assert property (
    acc.gp_hit |-> int'(acc.gp_index) < `BNK_GP_TOTAL)
    else $error("general register index out of range");

  AST_RD_PULSE: assert property (
    rd_go |=> rd_valid ##1 (!$past(clk_en) || rd_valid == $past(rd_go)))
    else $error("read valid not a single answer per read");

  AST_FREEZE: assert property (
    !clk_en |=> $stable(bank_pointer) && $stable(rd_valid))
    else $error("state moved while clock enable low");

  AST_RD_HOLDS: assert property (
    !rd_go |=> $stable(rd_data))
    else $error("read data moved without a read");

  AST_ADDR_HOLDS: assert property (
    !(clk_en && acc_valid)
    |=> $stable(access_addr) && $stable(access_mode))
    else $error("access address moved without an access");

  AST_DEDICATED_HOLD: assert property (
    !glob_wr |=> $stable(realtime_counter_value)
      && $stable(program_counter_low) && $stable(status_flags)
      && $stable(port_a_data) && $stable(port_b_data)
      && $stable(port_c_data))
    else $error("dedicated register changed without a write");

  AST_BANKED_GP: assert property (
    acc.mode == BNK_MODE_BANKED |-> acc.gp_hit)
    else $error("banked selector missed general storage");

  AST_SELF_WRITE_DROP: assert property (
    wr_go && sel == `BNK_SEL_INDIRECT
      && bank_pointer[`BNK_HALF_BIT:0] == `BNK_OFF_INDIRECT
      && !bank_strobe
    |=> $stable(bank_pointer))
    else $error("write through the indirect port to itself landed");
endmodule
`default_nettype wire

// ==== bnk_cpu_model.sv ====
// Purpose: core-side model that issues register accesses and bank commands
// Assumes: requests change on the falling edge, taken on the rising edge
// Notes:   read data is captured when rd_valid is seen, within four cycles
`include "bnk_defines.svh"
`default_nettype none
module bnk_cpu_model
  import bnk_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_valid,
  output logic                       clk_en,
  output logic      [`BNK_OPC_W-1:0] instr_opcode,
  output logic                       acc_valid,
  output logic                       acc_write,
  output logic      [7:0]            wr_data,
  output logic                       bank_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    clk_en       = 1'b1;
    instr_opcode = 12'h000;
    acc_valid    = 1'b0;
    acc_write    = 1'b0;
    wr_data      = 8'h00;
    bank_strobe  = 1'b0;
  end

  task automatic set_en(input logic e);
    @(negedge clk);
    clk_en = e;
  endtask

  task automatic access(input logic wr, input bnk_sel_t sel,
                        input bnk_byte_t d, output bnk_byte_t q);
    int n;
    @(negedge clk);
    instr_opcode = {7'h00, sel};
    acc_valid    = 1'b1;
    acc_write    = wr;
    wr_data      = d;
    @(negedge clk);
    acc_valid = 1'b0;
    // drive a changing value so stale write data is never mistaken
    wr_data   = ~d;
    q = 8'hXX;
    n = 0;
    if (!wr) begin
      while (rd_valid !== 1'b1 && n < 4) begin
        @(negedge clk);
        n++;
      end
      if (n < 4) q = rd_data;
    end
  endtask

  // write, then read the same selector in the very next cycle
  task automatic wr_rd(input bnk_sel_t sel, input bnk_byte_t d,
                       output bnk_byte_t q);
    @(negedge clk);
    instr_opcode = {7'h00, sel};
    acc_valid    = 1'b1;
    acc_write    = 1'b1;
    wr_data      = d;
    @(negedge clk);
    acc_write = 1'b0;
    wr_data   = ~d;
    @(negedge clk);
    acc_valid = 1'b0;
    q = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask

  // with wr set the selector is the pointer, so the bank field reads 4
  task automatic bank_cmd(input bnk_num_t b, input logic wr,
                          input bnk_byte_t d);
    @(negedge clk);
    instr_opcode = wr ? 12'h004 : {9'h000, b};
    bank_strobe  = 1'b1;
    acc_valid    = wr;
    acc_write    = wr;
    wr_data      = d;
    @(negedge clk);
    bank_strobe = 1'b0;
    acc_valid   = 1'b0;
    acc_write   = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench of the banked register file
// Assumes: one access per cycle from the core model
// Notes:   general RAM is not reset, so reads follow writes only
`include "bnk_defines.svh"
`default_nettype none
module tb_top
  import bnk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       clk_en, acc_valid, acc_write, bank_strobe, rd_valid;
  logic [11:0] instr_opcode;
  logic [7:0] wr_data, rd_data, bank_pointer, access_addr;
  logic [2:0] current_bank;
  logic [1:0] access_mode;
  wire  bnk_byte_t glob [8];
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  bnk_byte_t  q;

  always #12.5 clk = ~clk;

  bnk_regfile DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .instr_opcode(instr_opcode), .acc_valid(acc_valid),
    .acc_write(acc_write), .wr_data(wr_data), .bank_strobe(bank_strobe),
    .rd_data(rd_data), .rd_valid(rd_valid), .bank_pointer(bank_pointer),
    .current_bank(current_bank), .access_addr(access_addr),
    .access_mode(access_mode), .realtime_counter_value(glob[1]),
    .program_counter_low(glob[2]), .status_flags(glob[3]),
    .port_a_data(glob[5]), .port_b_data(glob[6]), .port_c_data(glob[7]));
  assign glob[0] = 8'h00;
  assign glob[4] = bank_pointer;

  bnk_cpu_model cpu (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .clk_en(clk_en), .instr_opcode(instr_opcode), .acc_valid(acc_valid),
    .acc_write(acc_write), .wr_data(wr_data), .bank_strobe(bank_strobe));

  task automatic chk(input bnk_byte_t got, input bnk_byte_t exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input bnk_sel_t s, input bnk_byte_t d);
    cpu.access(1'b1, s, d, q);
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
  endtask

  task automatic t_reset();
    chk(bank_pointer, 8'h00, "pointer after reset");
    chk({5'h00, current_bank}, 8'h00, "bank after reset");
    chk({6'h00, access_mode}, 8'h01, "mode after reset");
    chk({7'h00, rd_valid}, 8'h00, "rd_valid after reset");
    $display("test reset done");
  endtask

  task automatic t_globals();
    for (int k = 1; k < 8; k++)
      if (k != 4) wr(5'(k), 8'(8'h11 * k));
    for (int k = 1; k < 8; k++)
      if (k != 4) chk(glob[k], 8'(8'h11 * k), "dedicated global");
    wr(5'h08, 8'h5A);
    wr(5'h0F, 8'hC3);
    wr(5'h04, 8'hE0);
    cpu.wr_rd(5'h0E, 8'h3C, q);
    chk(q, 8'h3C, "global 0Eh back to back");
    cpu.access(1'b0, 5'h08, 8'h00, q);
    chk(q, 8'h5A, "global 08h from bank 7");
    cpu.access(1'b0, 5'h0F, 8'h00, q);
    chk(q, 8'hC3, "global 0Fh from bank 7");
    chk(access_addr, 8'h0F, "direct address");
    chk({6'h00, access_mode}, 8'h01, "direct mode");
    $display("test globals done");
  endtask

  task automatic t_banks();
    for (int b = 0; b < 8; b++) begin
      wr(5'h04, {3'(b), 5'h00});
      chk({5'h00, current_bank}, 8'(b), "current bank");
      wr(5'h1F, 8'(8'hA0 + b));
      chk(access_addr, {3'(b), 5'h1F}, "banked address");
      chk({6'h00, access_mode}, 8'h02, "banked mode");
      wr(5'h10, 8'(8'h60 + b));
    end
    cpu.wr_rd(5'h11, 8'h5B, q);
    chk(q, 8'h5B, "banked 11h back to back");
    for (int b = 0; b < 8; b++) begin
      wr(5'h04, {3'(b), 5'h00});
      cpu.access(1'b0, 5'h1F, 8'h00, q);
      chk(q, 8'(8'hA0 + b), "bank-private 1Fh");
      cpu.access(1'b0, 5'h10, 8'h00, q);
      chk(q, 8'(8'h60 + b), "bank-private 10h");
    end
    $display("test banks done");
  endtask

  task automatic t_indirect();
    wr(5'h04, 8'h3F);
    cpu.access(1'b0, 5'h00, 8'h00, q);
    chk(q, 8'hA1, "indirect 3Fh");
    chk(access_addr, 8'h3F, "indirect address");
    chk({6'h00, access_mode}, 8'h00, "indirect mode");
    wr(5'h00, 8'h99);
    cpu.access(1'b0, 5'h1F, 8'h00, q);
    chk(q, 8'h99, "indirect write lands");
    wr(5'h04, 8'hE5);
    cpu.access(1'b0, 5'h00, 8'h00, q);
    chk(q, 8'h55, "indirect lower half mirrors");
    wr(5'h04, 8'h00);
    wr(5'h00, 8'h42);
    cpu.access(1'b0, 5'h00, 8'h00, q);
    chk(q, 8'h00, "indirect port through itself");
    $display("test indirect done");
  endtask

  task automatic t_bankcmd();
    wr(5'h04, 8'h1F);
    cpu.bank_cmd(3'h5, 1'b0, 8'h00);
    chk(bank_pointer, 8'hBF, "bank command keeps low bits");
    chk({5'h00, current_bank}, 8'h05, "bank command");
    cpu.bank_cmd(3'h4, 1'b1, 8'h33);
    chk(bank_pointer, 8'h33, "full write wins");
    cpu.access(1'b0, 5'h04, 8'h00, q);
    chk(q, 8'h33, "pointer read at 04h");
    cpu.set_en(1'b0);
    wr(5'h06, 8'h77);
    cpu.set_en(1'b1);
    chk(glob[6], 8'h66, "frozen while disabled");
    $display("test bank command done");
  endtask

  task automatic t_rst2();
    wr(5'h04, 8'hC0);
    do_reset();
    chk({5'h00, current_bank}, 8'h00, "bank after second reset");
    chk(bank_pointer, 8'h00, "pointer after second reset");
    $display("test second reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("ERROR %0t run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_globals();
    t_banks();
    t_indirect();
    t_bankcmd();
    t_rst2();
    wrap_up();
  end
endmodule
`default_nettype wire
